// File: src/ihm_interp_chain.sv
// Two-stage half-band interpolation chain with coarse mixers for two channels.
// Assumes CLK is the full converter rate and that pin inputs are asynchronous.
//
// The address-and-strobe port and the address map were left to the implementer.
`default_nettype none

module ihm_halfband_stage
   import ihm_pkg::*;
(
   input wire logic clk, // Full-rate clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic ce_in, // Input sample enable
   input wire logic ce_out, // Output sample enable, twice ce_in
   input var ihm_pair_t din, // Input pair
   output ihm_pair_t dout // Output pair at twice the input rate
);
   ihm_sample_t din_ch [NUM_CH];
   ihm_sample_t dout_ch [NUM_CH];

   assign din_ch[0] = din.a;
   assign din_ch[1] = din.b;
   assign dout.a = dout_ch[0];
   assign dout.b = dout_ch[1];

   function automatic ihm_sample_t round_sat(input logic signed [ACC_W-1:0] v);
      logic signed [ACC_W-1:0] q;
      q = (v + ROUND_BIAS) >>> SCALE_SHIFT;
      if (q > SAT_MAX)
         return SAT_MAX[SAMPLE_W-1:0];
      else if (q < SAT_MIN)
         return SAT_MIN[SAMPLE_W-1:0];
      return q[SAMPLE_W-1:0];
   endfunction

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_ch
         ihm_sample_t line_reg [LINE_LEN];
         ihm_sample_t out_reg;
         logic signed [ACC_W-1:0] odd_acc;
         logic signed [ACC_W-1:0] centre_acc;

         // Zero-stuffing leaves only the symmetric pairs on one phase
         // and the lone centre tap on the other.
         always_comb
         begin
            odd_acc = '0;
            for (int j = 0; j < NUM_PAIRS; j++)
            begin
               odd_acc = odd_acc + ACC_W'(HB_COEF[j]) *
                  (ACC_W'(line_reg[j]) +
                   ACC_W'(line_reg[LINE_LEN-1-j]));
            end
         end

         // Line has advanced by one when the centre phase is emitted
         assign centre_acc = ACC_W'(line_reg[CENTER_SHIFTED_IDX]) *
            CENTER_COEF;

         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               for (int k = 0; k < LINE_LEN; k++)
               begin
                  line_reg[k] <= '0;
               end
            end
            else if (ce_in)
            begin
               line_reg[0] <= din_ch[ch];
               for (int k = 1; k < LINE_LEN; k++)
               begin
                  line_reg[k] <= line_reg[k-1];
               end
            end
         end

         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               out_reg <= '0;
            end
            else if (ce_out)
            begin
               out_reg <= ce_in ? round_sat(odd_acc)
                                : round_sat(centre_acc);
            end
         end

         assign dout_ch[ch] = out_reg;
      end
   endgenerate
endmodule // ihm_halfband_stage

module ihm_interp_chain
   import ihm_pkg::*;
(
   input wire logic CLK, // Full-rate converter clock
   input wire logic RST_B, // Asynchronous reset, active low
   input wire logic [SAMPLE_W-1:0] DATA_IN, // Interleaved sample pins
   input wire logic HALF_RATE_DATA_CLOCK, // Toggling data clock pin
   input wire logic TX_ENABLE_SYNC, // Transmit enable and sync pin
   input wire logic [ADDR_W-1:0] REG_ADDR, // Register address
   input wire logic [REG_W-1:0] REG_WDATA, // Register write data
   input wire logic REG_WR, // Write strobe
   input wire logic REG_RD, // Read strobe
   output logic [REG_W-1:0] REG_RDATA, // Read data, cycle after strobe
   output logic [SAMPLE_W-1:0] CONVERTER_A_INPUT, // Channel A to core
   output logic [SAMPLE_W-1:0] CONVERTER_B_INPUT // Channel B to core
);
   // Pin synchronisers
   logic [SAMPLE_W-1:0] data_meta_reg;
   logic [SAMPLE_W-1:0] data_sync_reg;
   logic dclk_meta_reg;
   logic dclk_sync_reg;
   logic dclk_prev_reg;
   logic tx_meta_reg;
   logic tx_sync_reg;
   logic tx_prev_reg;
   // Capture
   ihm_sample_t a_hold_reg;
   ihm_pair_t pair_reg;
   logic pair_seen_reg;
   // Configuration and rate control
   logic [CFG_USED_W-1:0] mixer_config_reg;
   logic [1:0] div_reg;
   logic [1:0] step1_reg;
   logic [1:0] step2_reg;
   logic [REG_W-1:0] rdata_reg;
   ihm_pair_t conv_reg;

   logic dclk_rise;
   logic dclk_fall;
   logic sync_event;
   logic x4_mode;
   logic real_mode;
   logic ce_half;
   logic ce_quarter;
   logic st1_ce_in;
   logic st1_ce_out;
   ihm_mix_mode_t first_mixer_select;
   ihm_mix_mode_t second_mixer_select;
   ihm_pair_t chain_feed;
   ihm_pair_t first_stage_out;
   ihm_pair_t first_mixer_out;
   ihm_pair_t second_stage_in;
   ihm_pair_t second_stage_out;
   ihm_pair_t second_mixer_out;

   // Coarse mixer shared by both points; step 0 is always +A, +B
   function automatic ihm_pair_t coarse_mix(input ihm_mix_mode_t mode,
                                            input logic [1:0] step,
                                            input ihm_pair_t p);
      ihm_pair_t r;
      r = p;
      unique case (mode)
         MIX_PASS:
            r = p;
         MIX_HIGHPASS:
            if (step[0])
            begin
               r.a = sat_neg(p.a);
               r.b = sat_neg(p.b);
            end
         MIX_PLUS_QTR:
            unique case (step)
               2'd0: r = p;
               2'd1: r = '{a: sat_neg(p.b), b: p.a};
               2'd2: r = '{a: sat_neg(p.a), b: sat_neg(p.b)};
               2'd3: r = '{a: p.b, b: sat_neg(p.a)};
            endcase
         MIX_MINUS_QTR:
            unique case (step)
               2'd0: r = p;
               2'd1: r = '{a: p.b, b: sat_neg(p.a)};
               2'd2: r = '{a: sat_neg(p.a), b: sat_neg(p.b)};
               2'd3: r = '{a: sat_neg(p.b), b: p.a};
            endcase
      endcase
      return r;
   endfunction

   // Real mode keeps A and B apart: any mixing becomes plain alternation
   function automatic ihm_mix_mode_t limit_mode(input logic [1:0] field,
                                                input logic real_en);
      if (real_en && field != MIX_PASS)
      begin
         return MIX_HIGHPASS;
      end
      return ihm_mix_mode_t'(field);
   endfunction

   // Two flops before any logic looks at a pin
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         data_meta_reg <= '0;
         data_sync_reg <= '0;
         dclk_meta_reg <= 1'b0;
         dclk_sync_reg <= 1'b0;
         dclk_prev_reg <= 1'b0;
         tx_meta_reg <= 1'b0;
         tx_sync_reg <= 1'b0;
         tx_prev_reg <= 1'b0;
      end
      else
      begin
         data_meta_reg <= DATA_IN;
         data_sync_reg <= data_meta_reg;
         dclk_meta_reg <= HALF_RATE_DATA_CLOCK;
         dclk_sync_reg <= dclk_meta_reg;
         dclk_prev_reg <= dclk_sync_reg;
         tx_meta_reg <= TX_ENABLE_SYNC;
         tx_sync_reg <= tx_meta_reg;
         tx_prev_reg <= tx_sync_reg;
      end
   end

   assign dclk_rise = dclk_sync_reg & ~dclk_prev_reg;
   assign dclk_fall = ~dclk_sync_reg & dclk_prev_reg;
   assign sync_event = tx_sync_reg & ~tx_prev_reg;

   // Rising edge carries A, falling edge B; the pair is split here so
   // every later rate is a per-channel rate.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         a_hold_reg <= '0;
         pair_reg <= PAIR_ZERO;
         pair_seen_reg <= 1'b0;
      end
      else
      begin
         if (dclk_rise)
         begin
            a_hold_reg <= data_sync_reg;
         end
         if (dclk_fall)
         begin
            pair_reg <= '{a: a_hold_reg, b: data_sync_reg};
            pair_seen_reg <= 1'b1;
         end
      end
   end

   // Disabled transmit path flushes the filters with silence
   assign chain_feed = tx_sync_reg ? pair_reg : PAIR_ZERO;

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         mixer_config_reg <= CFG_RESET[CFG_USED_W-1:0];
      else if (REG_WR && REG_ADDR == ADDR_MIXER_CFG)
         mixer_config_reg <= REG_WDATA[CFG_USED_W-1:0];
   end

   assign x4_mode = mixer_config_reg[CFG_X4_BIT];
   assign real_mode = mixer_config_reg[CFG_REAL_BIT];
   assign first_mixer_select = limit_mode(
      mixer_config_reg[CFG_FIRST_LSB +: 2], real_mode);
   assign second_mixer_select = limit_mode(
      mixer_config_reg[CFG_SECOND_LSB +: 2], real_mode);

   // Read data exists only in the cycle after the strobe
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rdata_reg <= RDATA_IDLE;
      end
      else
      begin
         rdata_reg <= RDATA_IDLE;
         if (REG_RD && REG_ADDR == ADDR_MIXER_CFG)
         begin
            rdata_reg <= REG_W'(mixer_config_reg);
         end
         else if (REG_RD && REG_ADDR == ADDR_STATUS)
         begin
            rdata_reg[ST_SYNC_BIT] <= tx_sync_reg;
            rdata_reg[ST_PAIR_BIT] <= pair_seen_reg;
            rdata_reg[ST_STEP_LSB +: 2] <= step2_reg;
         end
      end
   end

   // Free-running divider; filter stages run on its enables, the
   // output path on every edge.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         div_reg <= DIV_RESET;
      else
         div_reg <= div_reg + 2'd1;
   end

   assign ce_half = div_reg[0];
   assign ce_quarter = &div_reg;
   assign st1_ce_in = ce_quarter & x4_mode;
   assign st1_ce_out = ce_half & x4_mode;

   ihm_halfband_stage u_first_halfband_stage (
      .clk(CLK),
      .rst_b(RST_B),
      .ce_in(st1_ce_in),
      .ce_out(st1_ce_out),
      .din(chain_feed),
      .dout(first_stage_out)
   );

   // Step moves with each stage output, so a sync parks it just
   // before the first phase of the sequence.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         step1_reg <= STEP_BEFORE_FIRST;
      else if (sync_event)
         step1_reg <= STEP_BEFORE_FIRST;
      else if (st1_ce_out)
         step1_reg <= step1_reg + 2'd1;
   end

   // Running at half the output rate, a quarter-rate rotation here
   // lands as an eighth-rate shift at the converter.
   assign first_mixer_out = coarse_mix(first_mixer_select, step1_reg,
                                       first_stage_out);
   assign second_stage_in = x4_mode ? first_mixer_out
                                    : chain_feed;

   ihm_halfband_stage u_second_halfband_stage (
      .clk(CLK),
      .rst_b(RST_B),
      .ce_in(ce_half),
      .ce_out(1'b1),
      .din(second_stage_in),
      .dout(second_stage_out)
   );

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         step2_reg <= STEP_FIRST;
      else if (sync_event)
         step2_reg <= STEP_FIRST;
      else
         step2_reg <= step2_reg + 2'd1;
   end

   // High-pass here mirrors the band about the data rate
   assign second_mixer_out = coarse_mix(second_mixer_select, step2_reg,
                                        second_stage_out);

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         conv_reg <= PAIR_ZERO;
      else
         conv_reg <= second_mixer_out;
   end

   assign CONVERTER_A_INPUT = conv_reg.a;
   assign CONVERTER_B_INPUT = conv_reg.b;
   assign REG_RDATA = rdata_reg;
endmodule // ihm_interp_chain

`default_nettype wire

// File: pkg/ihm_pkg.sv
// Shared constants, types and helpers for the half-band interpolator chain.
// Assumes one full-rate clock; slower rates are enables derived from it.
`default_nettype none
package ihm_pkg;
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 40;
   localparam int NUM_PAIRS = 12;
   localparam int LINE_LEN = 24;
   localparam int CENTER_SHIFTED_IDX = 12;
   localparam int SCALE_SHIFT = 15;
   localparam int NUM_CH = 2;
   localparam logic signed [ACC_W-1:0] CENTER_COEF = 40'sd16384;
   localparam logic signed [ACC_W-1:0] ROUND_BIAS = 40'sd16384;
   localparam logic signed [ACC_W-1:0] SAT_MAX = 40'sd32767;
   localparam logic signed [ACC_W-1:0] SAT_MIN = -40'sd32768;
   // Outer pair first, innermost pair last
   localparam logic signed [15:0] HB_COEF [NUM_PAIRS] = '{
      -16'sd5, 16'sd18, -16'sd42, 16'sd85, -16'sd158, 16'sd272,
      -16'sd444, 16'sd704, -16'sd1106, 16'sd1795, -16'sd3295, 16'sd10368};
   // Register port
   localparam int ADDR_W = 4;
   localparam int REG_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_MIXER_CFG = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
   localparam logic [REG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [REG_W-1:0] RDATA_IDLE = 8'h00;
   localparam int CFG_FIRST_LSB = 0;
   localparam int CFG_SECOND_LSB = 2;
   localparam int CFG_X4_BIT = 4;
   localparam int CFG_REAL_BIT = 5;
   localparam int CFG_USED_W = 6;
   localparam int ST_SYNC_BIT = 0;
   localparam int ST_PAIR_BIT = 1;
   localparam int ST_STEP_LSB = 2;
   // Rate divider and mixer step
   localparam logic [1:0] DIV_RESET = 2'h0;
   localparam logic [1:0] STEP_FIRST = 2'h0;
   localparam logic [1:0] STEP_BEFORE_FIRST = 2'h3;

   typedef logic signed [SAMPLE_W-1:0] ihm_sample_t;
   typedef struct packed {
      ihm_sample_t a;
      ihm_sample_t b;
   } ihm_pair_t;
   typedef enum logic [1:0] {
      MIX_PASS,
      MIX_HIGHPASS,
      MIX_PLUS_QTR,
      MIX_MINUS_QTR
   } ihm_mix_mode_t;

   localparam ihm_pair_t PAIR_ZERO = '0;

   // Negation that cannot wrap the most negative code
   function automatic ihm_sample_t sat_neg(input ihm_sample_t x);
      return (x == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? ~x : -x;
   endfunction
endpackage : ihm_pkg
`default_nettype wire

// File: sim/ihm_chain_sva.sv
// Port checker for the interpolator chain.
// Assumes the single full-rate clock and the chain's register port.
`default_nettype none
module ihm_chain_sva
   import ihm_pkg::*;
(
   input wire logic CLK, // Clock
   input wire logic RST_B, // Reset, active low
   input wire logic TX_ENABLE_SYNC, // Enable pin
   input wire logic [ADDR_W-1:0] REG_ADDR, // Address
   input wire logic [REG_W-1:0] REG_WDATA, // Write data
   input wire logic REG_WR, // Write strobe
   input wire logic REG_RD, // Read strobe
   input wire logic [REG_W-1:0] REG_RDATA, // Read data
   input wire logic [SAMPLE_W-1:0] CONVERTER_A_INPUT, // Channel A
   input wire logic [SAMPLE_W-1:0] CONVERTER_B_INPUT // Channel B
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] cfg_reg;
   logic [7:0] lo_reg;
   logic [7:0] hi_reg;
   logic hi_long;
   logic [1:0] step_now;
   assign hi_long = hi_reg >= 8'h08;
   assign step_now = REG_RDATA[ST_STEP_LSB+:2];
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         cfg_reg <= 6'h00;
      else if (REG_WR && REG_ADDR == ADDR_MIXER_CFG)
         cfg_reg <= REG_WDATA[5:0];
   end
   // Saturating run lengths of the enable pin level
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         lo_reg <= 8'h00;
         hi_reg <= 8'h00;
      end
      else
      begin
         lo_reg <= TX_ENABLE_SYNC ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hFF};
         hi_reg <= !TX_ENABLE_SYNC ? 8'h00 : hi_reg + {7'h00, hi_reg != 8'hFF};
      end
   end
   a_rdata_idle: assert property (
      !REG_RD |=> REG_RDATA == RDATA_IDLE) else $error("read data not idle");
   a_cfg_readback: assert property (
      REG_RD && REG_ADDR == ADDR_MIXER_CFG |=> REG_RDATA == {2'h0, cfg_reg})
      else $error("config readback differs");
   a_unmapped_zero: assert property (
      REG_RD && REG_ADDR != ADDR_MIXER_CFG && REG_ADDR != ADDR_STATUS
      |=> REG_RDATA == RDATA_IDLE) else $error("unmapped read not zero");
   a_status_spare: assert property (
      REG_RD && REG_ADDR == ADDR_STATUS |=> REG_RDATA[7:4] == 4'h0)
      else $error("status spare bits set");
   a_step_advance: assert property (
      REG_RD && REG_ADDR == ADDR_STATUS && hi_long ##1
      REG_RD && REG_ADDR == ADDR_STATUS |=> step_now == $past(step_now) + 2'h1)
      else $error("mixer step did not advance");
   a_sync_flag: assert property (
      REG_RD && REG_ADDR == ADDR_STATUS && (hi_long || lo_reg >= 8'h08)
      |=> REG_RDATA[ST_SYNC_BIT] == $past(hi_long))
      else $error("enable flag wrong");
   a_tx_low_zero: assert property (
      lo_reg >= 8'hFA |-> CONVERTER_A_INPUT == '0 && CONVERTER_B_INPUT == '0)
      else $error("output not zero while disabled");
   a_reset_quiet: assert property (
      $rose(RST_B) |-> CONVERTER_A_INPUT == '0 ##1 REG_RDATA == RDATA_IDLE)
      else $error("output active after reset");
endmodule // ihm_chain_sva
bind ihm_interp_chain ihm_chain_sva chk_u (.CLK, .RST_B, .TX_ENABLE_SYNC,
   .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CONVERTER_A_INPUT,
   .CONVERTER_B_INPUT);
`default_nettype wire

// File: sim/ihm_src.sv
// Sample source model standing for the logic that feeds the chain.
// Assumes the chain clock; one A/B pair every 12 cycles, edges 6 apart.
`default_nettype none
module ihm_src
   import ihm_pkg::*;
(
   input wire logic clk, // Full-rate clock
   input wire logic rst_b, // Reset, active low
   input wire logic [SAMPLE_W-1:0] val_a, // Channel A value
   input wire logic [SAMPLE_W-1:0] val_b, // Channel B value
   input wire logic tx_en, // Requested enable level
   output logic [SAMPLE_W-1:0] data_o, // Interleaved sample pins
   output logic dclk_o, // Half-rate data clock
   output logic sync_o // Enable and sync pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ph_reg;
   // Data held 3 cycles either side of each data clock edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ph_reg <= 4'h0;
         data_o <= '0;
         dclk_o <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         ph_reg <= (ph_reg == 4'hB) ? 4'h0 : ph_reg + 4'h1;
         sync_o <= tx_en;
         case (ph_reg)
            4'h0: data_o <= val_a;
            4'h3: dclk_o <= 1'b1;
            4'h6: data_o <= val_b;
            4'h9: dclk_o <= 1'b0;
            default: ;
         endcase
      end
   end
endmodule // ihm_src
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the interpolator chain.
// Assumes a 20 MHz clock and the sample source model at the pins.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ihm_pkg::*;
   logic CLK, RST_B, REG_WR, REG_RD, dclk, sync, tx_en;
   logic [ADDR_W-1:0] REG_ADDR;
   logic [REG_W-1:0] REG_WDATA, REG_RDATA;
   logic [SAMPLE_W-1:0] din, out_a, out_b;
   ihm_sample_t val_a, val_b;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   ihm_src src_u (.clk(CLK), .rst_b(RST_B), .val_a, .val_b, .tx_en,
      .data_o(din), .dclk_o(dclk), .sync_o(sync));
   ihm_interp_chain dut_u (.CLK, .RST_B, .DATA_IN(din),
      .HALF_RATE_DATA_CLOCK(dclk), .TX_ENABLE_SYNC(sync), .REG_ADDR,
      .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
      .CONVERTER_A_INPUT(out_a), .CONVERTER_B_INPUT(out_b));

   initial
   begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Run should take about 4900 cycles
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         n_errors++;
         test_done();
      end
   end

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(logic [ADDR_W-1:0] addr, logic [REG_W-1:0] data);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= addr;
      REG_WDATA <= data;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask

   // Two back-to-back reads of one address
   task automatic reg_rd(logic [ADDR_W-1:0] addr, output logic [7:0] d1, d2);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= addr;
      @(posedge CLK);
      #1 d1 = REG_RDATA;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d2 = REG_RDATA;
   endtask

   // One stage at DC: both polyphase branches sum to 16384, then round
   function automatic ihm_sample_t half(ihm_sample_t x);
      logic signed [SAMPLE_W:0] t;
      t = x + 17'sh00001;
      return t[SAMPLE_W:1];
   endfunction

   function automatic ihm_pair_t mixed(ihm_pair_t y, logic [1:0] m, int s);
      ihm_pair_t r;
      int k;
      k = (m == 2'h3) ? (4 - s) % 4 : s;
      r = y;
      if (m == 2'h1 && s % 2 == 1) r = '{-y.a, -y.b};
      if (m[1] && k == 1) r = '{-y.b, y.a};
      if (m[1] && k == 2) r = '{-y.a, -y.b};
      if (m[1] && k == 3) r = '{y.b, -y.a};
      return r;
   endfunction

   task automatic t_regs();
      logic [7:0] d1, d2;
      reg_rd(ADDR_MIXER_CFG, d1, d2);
      check("config reset", CFG_RESET, d1);
      reg_wr(ADDR_MIXER_CFG, 8'hFF);
      reg_wr(4'h7, 8'hAA);
      reg_rd(4'h7, d1, d2);
      check("unmapped read", RDATA_IDLE, d1);
      reg_rd(ADDR_MIXER_CFG, d1, d2);
      check("config bits", 8'h3F, d2);
      reg_rd(ADDR_STATUS, d1, d2);
      check("mixer step", 2'(d1[3:2] + 2'h1), d2[3:2]);
      check("pair seen", 1'b1, d1[ST_PAIR_BIT]);
      check("enable seen", 1'b1, d1[ST_SYNC_BIT]);
      reg_wr(ADDR_MIXER_CFG, 8'h00);
      $display("test registers done");
   endtask

   task automatic t_txoff();
      logic [7:0] d1, d2;
      @(posedge CLK);
      tx_en <= 1'b0;
      repeat (300) @(posedge CLK);
      #1 check("idle a", 16'h0000, out_a);
      check("idle b", 16'h0000, out_b);
      reg_rd(ADDR_STATUS, d1, d2);
      check("enable clear", 1'b0, d1[ST_SYNC_BIT]);
      @(posedge CLK);
      tx_en <= 1'b1;
      $display("test enable low done");
   endtask

   // Four settled outputs must be one rotation of the mixing sequence.
   // With gap, a first-stage high-pass image cancels in the second
   // stage's pair branch: only the centre tap passes, every other output.
   task automatic run_mix(logic [7:0] cfg, logic [1:0] m, ihm_pair_t y,
                          bit gap = 1'b0);
      ihm_pair_t seen [4];
      ihm_pair_t e;
      int hit, k, s;
      reg_wr(ADDR_MIXER_CFG, cfg);
      repeat (400) @(posedge CLK);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge CLK);
         #1 seen[i] = '{out_a, out_b};
      end
      hit = 0;
      for (int r = 0; r < 4; r++)
      begin
         k = 0;
         for (int i = 0; i < 4; i++)
         begin
            s = (r + i) % 4;
            if (gap)
               e = s[0] ? mixed(y, 2'h1, s / 2) : PAIR_ZERO;
            else
               e = mixed(y, m, s);
            k += int'(seen[i] === e);
         end
         if (k == 4) hit = 1;
      end
      n_checks++;
      if (hit != 1)
      begin
         n_errors++;
         $display("wrong value mix cfg %h expected %h seen %h", cfg,
            mixed(y, m, 0), seen[0]);
      end
      $display("test mix cfg %h done", cfg);
   endtask

   initial
   begin
      ihm_pair_t y2, y4;
      RST_B = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = '0;
      REG_WDATA = '0;
      tx_en = 1'b0;
      val_a = 16'sh1234;
      val_b = 16'shF100;
      y2 = '{half(val_a), half(val_b)};
      y4 = '{half(y2.a), half(y2.b)};
      repeat (6) @(posedge CLK);
      RST_B <= 1'b1;
      tx_en <= 1'b1;
      repeat (100) @(posedge CLK);
      t_regs();
      t_txoff();
      for (int m = 0; m < 4; m++)
         run_mix({4'h0, 2'(m), 2'h0}, 2'(m), y2);
      run_mix(8'h03, 2'h0, y2);
      run_mix(8'h10, 2'h0, y4);
      run_mix(8'h14, 2'h1, y4);
      run_mix(8'h11, 2'h1, y4, 1'b1);
      run_mix(8'h32, 2'h1, y4, 1'b1);
      run_mix(8'h28, 2'h1, y2);
      run_mix(8'h2C, 2'h1, y2);
      test_done();
   end
endmodule // testbench
`default_nettype wire
